// ===== logic/acst_pkg.sv
// constants for the accelerometer status and timestamp register group
package acst_pkg;
  // ==========================================================
  // register indices (printed offsets are not word aligned)
  localparam logic [7:0] ACST_IDX_ACC_Z_HI   = 8'h17;
  localparam logic [7:0] ACST_IDX_TS_B0      = 8'h18;
  localparam logic [7:0] ACST_IDX_TS_B1      = 8'h19;
  localparam logic [7:0] ACST_IDX_TS_B2      = 8'h1A;
  localparam logic [7:0] ACST_IDX_PWR_FLAGS  = 8'h1B;
  localparam logic [7:0] ACST_IDX_FEAT_IRQ   = 8'h1C;
  localparam logic [7:0] ACST_IDX_DATA_IRQ   = 8'h1D;
  localparam logic [7:0] ACST_IDX_IRQ_MASK0  = 8'h30;
  localparam logic [7:0] ACST_IDX_IRQ_MASK1  = 8'h31;
  localparam logic [7:0] ACST_IDX_IRQ_PEND   = 8'h32;
  localparam logic [7:0] ACST_IDX_SOFT_RST   = 8'h33;
  localparam int         ACST_IDX_SHIFT      = 2;
  // ==========================================================
  // reset values
  localparam logic [7:0] ACST_RST_PWR_FLAGS  = 8'h01;
  localparam logic [7:0] ACST_RST_ZERO       = 8'h00;
  localparam logic [7:0] ACST_SOFT_RST_CMD   = 8'hB6;
  // ==========================================================
  // field layouts
  localparam logic [7:0] ACST_FEAT_MASK      = 8'hEE;
  localparam logic [7:0] ACST_DATA_MASK      = 8'hA3;
  localparam int         ACST_FEAT_ACTIVITY  = 2;
  localparam int         ACST_DATA_ACC_RDY   = 7;
  localparam int         ACST_DATA_AUX_RDY   = 5;
  localparam int         ACST_DATA_FWM       = 1;
  localparam int         ACST_DATA_FFULL     = 0;
  localparam int         ACST_PEND_BITS      = 3;
  // ==========================================================
  // timing: tick period in nanoseconds, clock period in ns
  localparam real        ACST_TICK_NS        = 39062.5;
  localparam real        ACST_CLK_NS         = 40.0;
  localparam int         ACST_TS_WIDTH       = 24;
endpackage : acst_pkg

// ===== logic/acst_tick_div.sv
// divider producing the sensor time tick enable
`timescale 1ns/1ns
module acst_tick_div #(
  parameter int unsigned DIV = 977
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  output logic      tick_o
);
  logic [15:0] cnt_q;

  // ==========================================================
  // count down, one pulse per wrap
  always_ff @(posedge clk_i) begin
    if (rst_i || cnt_q == 16'h0000) begin
      cnt_q <= 16'(DIV - 1);
    end else begin
      cnt_q <= cnt_q - 16'h0001;
    end
  end

  // held low in reset so no tick escapes early
  assign tick_o = !rst_i && (cnt_q == 16'h0000);
endmodule : acst_tick_div

// ===== logic/acst_regs.sv
// status, timestamp and clear-on-read interrupt registers
`timescale 1ns/1ns
module acst_regs
  import acst_pkg::*;
#(
  parameter int unsigned TICK_DIV = 977
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic [7:0]  accel_z_hi_i,
  input  wire logic        step_evt_i,
  input  wire logic        activity_evt_i,
  input  wire logic        wrist_tilt_evt_i,
  input  wire logic        wakeup_evt_i,
  input  wire logic        motion_evt_i,
  input  wire logic        error_evt_i,
  input  wire logic        acc_rdy_evt_i,
  input  wire logic        aux_rdy_evt_i,
  input  wire logic        fifo_wm_evt_i,
  input  wire logic        fifo_full_evt_i,
  output logic             irq_o
);
  import acst_pkg::*;

  logic [ACST_TS_WIDTH-1:0] ts_q;
  logic [7:0]  pwr_q;
  logic [7:0]  feat_q;
  logic [7:0]  data_q;
  logic [7:0]  mask0_q;
  logic [7:0]  mask1_q;
  logic [7:0]  feat_evt;
  logic [7:0]  data_evt;
  logic [7:0]  idx;
  logic        tick;
  logic        req;
  logic        rd;
  logic        wr;
  logic        lane0;
  logic        hit;
  logic        soft_rst_q;
  logic        any_rst;
  logic [7:0]  rdata;

  // ==========================================================
  // bus decode: one byte register per aligned word, low lane
  assign idx   = 8'(wb_adr_i >> ACST_IDX_SHIFT);
  assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign lane0 = wb_sel_i[0];
  assign rd    = req && !wb_we_i && hit;
  assign wr    = req && wb_we_i && hit && lane0;
  // soft reset restores flags, timestamp and tick like the external reset; masks are kept
  assign any_rst = rst_i || soft_rst_q;

  // ==========================================================
  // sensor time tick
  acst_tick_div #(
    .DIV    (TICK_DIV)
  ) u_tick (
    .clk_i  (clk_i),
    .rst_i  (any_rst),
    .tick_o (tick)
  );

  // free-running counter, natural wrap at 2^24
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      ts_q <= '0;
    end else if (tick) begin
      ts_q <= ts_q + 1'b1;
    end
  end

  // ==========================================================
  // event vectors placed at their status bit positions
  always_comb begin
    feat_evt = {error_evt_i, motion_evt_i, wakeup_evt_i, 1'b0,
                wrist_tilt_evt_i, 1'b0, step_evt_i, 1'b0};
    feat_evt[ACST_FEAT_ACTIVITY] = activity_evt_i;
    data_evt = ACST_RST_ZERO;
    data_evt[ACST_DATA_ACC_RDY] = acc_rdy_evt_i;
    data_evt[ACST_DATA_AUX_RDY] = aux_rdy_evt_i;
    data_evt[ACST_DATA_FWM]     = fifo_wm_evt_i;
    data_evt[ACST_DATA_FFULL]   = fifo_full_evt_i;
  end

  // power-up flag: set by any reset, cleared by a read
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      pwr_q <= ACST_RST_PWR_FLAGS;
    end else if (rd && idx == ACST_IDX_PWR_FLAGS) begin
      pwr_q <= ACST_RST_ZERO;
    end
  end

  // feature flags: sticky, read clears, a coincident event survives
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      feat_q <= ACST_RST_ZERO;
    end else if (rd && idx == ACST_IDX_FEAT_IRQ) begin
      feat_q <= feat_evt & ACST_FEAT_MASK;
    end else begin
      feat_q <= (feat_q | feat_evt) & ACST_FEAT_MASK;
    end
  end

  // data and buffer flags, same scheme; reserved bits forced zero
  always_ff @(posedge clk_i) begin
    if (any_rst) begin
      data_q <= ACST_RST_ZERO;
    end else if (rd && idx == ACST_IDX_DATA_IRQ) begin
      data_q <= data_evt & ACST_DATA_MASK;
    end else begin
      data_q <= (data_q | data_evt) & ACST_DATA_MASK;
    end
  end

  // ==========================================================
  // masks and soft reset command
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask0_q <= ACST_RST_ZERO;
      mask1_q <= ACST_RST_ZERO;
    end else if (wr && idx == ACST_IDX_IRQ_MASK0) begin
      mask0_q <= wb_dat_i[7:0];
    end else if (wr && idx == ACST_IDX_IRQ_MASK1) begin
      mask1_q <= wb_dat_i[7:0];
    end
  end

  // one-cycle pulse; masks survive soft reset on purpose
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_rst_q <= 1'b0;
    end else begin
      soft_rst_q <= wr && idx == ACST_IDX_SOFT_RST &&
                    wb_dat_i[7:0] == ACST_SOFT_RST_CMD;
    end
  end

  // level interrupt from unmasked flags
  assign irq_o = |(feat_q & mask0_q) || |(data_q & mask1_q) ||
                 (pwr_q[0] && mask1_q[ACST_DATA_FWM + 1]);

  // ==========================================================
  // read mux
  always_comb begin
    hit   = 1'b1;
    rdata = ACST_RST_ZERO;
    case (idx)
      ACST_IDX_ACC_Z_HI:  rdata = accel_z_hi_i;
      ACST_IDX_TS_B0:     rdata = ts_q[7:0];
      ACST_IDX_TS_B1:     rdata = ts_q[15:8];
      ACST_IDX_TS_B2:     rdata = ts_q[23:16];
      ACST_IDX_PWR_FLAGS: rdata = pwr_q;
      ACST_IDX_FEAT_IRQ:  rdata = feat_q;
      ACST_IDX_DATA_IRQ:  rdata = data_q;
      ACST_IDX_IRQ_MASK0: rdata = mask0_q;
      ACST_IDX_IRQ_MASK1: rdata = mask1_q;
      ACST_IDX_IRQ_PEND:  rdata = 8'({irq_o, |(data_q & mask1_q),
                                      |(feat_q & mask0_q)});
      ACST_IDX_SOFT_RST:  rdata = ACST_RST_ZERO;
      default:            hit   = 1'b0;
    endcase
  end

  // ==========================================================
  // one-cycle registered answer; unmapped gives err
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req && hit;
      wb_err_o <= req && !hit;
      wb_dat_o <= (req && !wb_we_i && hit) ? {24'h00_0000, rdata} : '0;
    end
  end
endmodule : acst_regs

// ===== testbench/acst_regs_asserts.sv
// assertion checker for the status and timestamp registers
`timescale 1ns/1ns
module acst_regs_asserts (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [9:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic [7:0]  accel_z_hi_i,
  input wire logic        step_evt_i,
  input wire logic        activity_evt_i,
  input wire logic        wrist_tilt_evt_i,
  input wire logic        wakeup_evt_i,
  input wire logic        motion_evt_i,
  input wire logic        error_evt_i,
  input wire logic        acc_rdy_evt_i,
  input wire logic        aux_rdy_evt_i,
  input wire logic        fifo_wm_evt_i,
  input wire logic        fifo_full_evt_i,
  input wire logic        irq_o
);
  // ==========================================================
  // request decode; address is held until the answer
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire logic rd = wb_ack_o & ~wb_we_i;
  wire logic [7:0] ix = wb_adr_i[9:2];
  wire logic um = !(ix inside {[8'h17:8'h1D], [8'h30:8'h33]});
  AST_ANSWER: assert property (tk |=> wb_ack_o ^ wb_err_o)
    else $error("request not answered once");
  AST_ERR_MAP: assert property (tk && um |=> wb_err_o)
    else $error("unmapped index not refused");
  AST_NO_ERR: assert property (tk && !um |=> !wb_err_o)
    else $error("mapped index refused");
  AST_WR_ZERO: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 0)
    else $error("write answer carries data");
  AST_PWR_RSVD: assert property (rd && ix == 8'h1B |-> wb_dat_o < 2)
    else $error("power flag reserved bits set");
  AST_FEAT_RSVD: assert property (rd && ix == 8'h1C |->
    (wb_dat_o & 32'hFFFF_FF11) == 0) else $error("feature reserved set");
  AST_DATA_RSVD: assert property (rd && ix == 8'h1D |->
    (wb_dat_o & 32'hFFFF_FF5C) == 0) else $error("data reserved set");
  AST_ZHI: assert property (rd && ix == 8'h17 |->
    wb_dat_o[7:0] == $past(accel_z_hi_i)) else $error("z byte wrong");
  cover property (rd && ix == 8'h1C && wb_dat_o[2]);
  cover property (wb_err_o);
  cover property ($rose(irq_o));
endmodule : acst_regs_asserts

// ===== testbench/tb_acst_regs.sv
// self-checking bench for the status and timestamp registers
`timescale 1ns/1ns
module tb_acst_regs;
  import acst_pkg::*;
  // ==========================================================
  // stimulus and expectation queues; ticks shortened to TD
  localparam int TD = 2;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [9:0] wb_adr_i = '0, ev = '0, r;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic [7:0] accel_z_hi_i = '0;
  logic wb_ack_o, wb_err_o, irq_o;
  logic [32:0] eq[$], mq[$];
  wire step_evt_i, activity_evt_i, wrist_tilt_evt_i, wakeup_evt_i;
  wire motion_evt_i, error_evt_i, acc_rdy_evt_i, aux_rdy_evt_i;
  wire fifo_wm_evt_i, fifo_full_evt_i;
  int fail_count = 0, n_compared = 0, seed = 94;
  realtime t0;
  assign {error_evt_i, motion_evt_i, wakeup_evt_i, wrist_tilt_evt_i,
          activity_evt_i, step_evt_i} = ev[5:0];
  assign {acc_rdy_evt_i, aux_rdy_evt_i, fifo_wm_evt_i,
          fifo_full_evt_i} = ev[9:6];
  acst_regs #(.TICK_DIV(TD)) dut_u (.*);
  always #20 clk_i = ~clk_i;
  task automatic chk(logic [32:0] g, logic [32:0] x);
    n_compared++;
    if (g !== x) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk
  // one classic cycle; waits for the answer, then releases
  task automatic bus(logic w, logic [7:0] ix, logic [7:0] d,
                     logic [32:0] x, logic [32:0] k = 33'h1_FFFF_FFFF);
    eq.push_back(x);
    mq.push_back(k);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {ix, 2'b00, 4'h1, 24'h0, d};
    // no cycle count assumed; only the watchdog ends a hung wait
    do @(posedge clk_i); while (!(wb_ack_o | wb_err_o));
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : bus
  task automatic pulse(logic [9:0] v);
    @(posedge clk_i) ev <= v;
    @(posedge clk_i) ev <= '0;
    #1;
  endtask : pulse
  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run
  // monitor takes the oldest note at every answer
  always @(posedge clk_i) if (wb_ack_o | wb_err_o) begin : mon_b
    logic [32:0] k, x;
    k = 33'h0;
    x = 33'h0;
    if (eq.size() == 0) begin
      fail_count++;
      $display("ERROR t=%0t got %h exp %h", $time, {wb_err_o, wb_dat_o},
               33'h0);
    end else begin
      k = mq.pop_front();
      x = eq.pop_front();
      chk({wb_err_o, wb_dat_o} & k, x & k);
    end
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    accel_z_hi_i <= 8'($random(seed));
    t0 = $realtime;
    bus(0, 8'h1B, 0, 33'h01);
    bus(0, 8'h1B, 0, 33'h00);
    bus(1, 8'h1C, 8'hFF, 33'h00);
    bus(0, 8'h1C, 0, 33'h00);
    bus(0, 8'h1D, 0, 33'h00);
    bus(1, 8'h17, 8'h5A, 33'h00);
    bus(0, 8'h17, 0, {25'h0, accel_z_hi_i});
    bus(0, 8'h40, 0, 33'h1_0000_0000, 33'h1_0000_0000);
    while ($realtime - t0 < 720 * 40) @(posedge clk_i);
    bus(0, 8'h18, 0, 33'((720 / TD) & 'hF0), 33'h1_FFFF_FFF0);
    bus(0, 8'h19, 0, 33'((720 / TD) >> 8));
    bus(0, 8'h1A, 0, 33'h00);
    repeat (8) begin
      r = 10'($random(seed));
      pulse(r);
      bus(0, 8'h1C, 0, {25'h0, r[5:3], 1'b0, r[2:0], 1'b0});
      bus(0, 8'h1D, 0, {25'h0, r[9], 1'b0, r[8], 3'h0, r[7:6]});
    end
    bus(1, 8'h30, 8'h04, 33'h00);
    pulse(10'h001);
    chk(33'(irq_o), 33'h0);
    bus(0, 8'h1C, 0, 33'h02);
    pulse(10'h002);
    chk(33'(irq_o), 33'h1);
    bus(0, 8'h1C, 0, 33'h04);
    #1 chk(33'(irq_o), 33'h0);
    bus(1, ACST_IDX_SOFT_RST, ACST_SOFT_RST_CMD, 33'h00);
    bus(0, 8'h1B, 0, 33'h01);
    bus(0, 8'h19, 0, 33'h00);
    complete_run;
  end
  // watchdog cuts a hung handshake short
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    complete_run;
  end
endmodule : tb_acst_regs
bind acst_regs acst_regs_asserts ast_u (.*);
